// >>> design/prot_ctrl_pkg.sv
// Purpose: shared constants and types of the feeder protection and control logic
// Assumes: 50 MHz system clock; currents arrive as unsigned magnitudes on that clock
// Notes: timing counts are derived from the clock rate, never written as bare figures
package prot_ctrl_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // clock and timing
  localparam int CLK_HZ = 50_000_000;
  localparam int TICK_US = 1000; // protection timers count in 1 ms steps
  localparam int TICK_CYCLES = (CLK_HZ / 1_000_000) * TICK_US;
  localparam int PULSE_TICKS = 200; // open/close pulse length in ticks
  localparam int TICK_W = 16;
  localparam int PULSE_W = 16;

  ////////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int CUR_W = 12;
  localparam int TIME_W = 16;
  localparam int ACC_W = 28;
  localparam int INV_SCALE = 64; // inverse curve: excess current x ms per set unit
  localparam int NUM_STAGES = 4;
  localparam int NUM_GEN = 10;
  localparam int NUM_EXT = 6;
  localparam int NUM_OBJ = 3;
  localparam int NUM_SIG = 4;
  localparam int ILK_W = 16;
  localparam int SYNC_W = 16;

  ////////////////////////////////////////////////////////////////////////////////
  // stage indices and characteristics
  localparam int STG_OC_LOW = 0;
  localparam int STG_OC_HIGH = 1;
  localparam int STG_EF_LOW = 2;
  localparam int STG_EF_HIGH = 3;

  typedef enum logic [1:0] {
    CHAR_DEFINITE = 2'h0,
    CHAR_INVERSE = 2'h1,
    CHAR_INSTANT = 2'h2
  } char_t;

  ////////////////////////////////////////////////////////////////////////////////
  // default interlocking schemes over {general[9:0], closed[2:0], open[2:0]}
  // scheme 0: free; 1: close needs object 2 closed; 2: also object 3 open;
  // 3: open and close need object 3 (earthing) open
  localparam logic [15:0] DEF_OPEN_MASK [0:3] = '{16'h0000, 16'h0000, 16'h0000, 16'h0004};
  localparam logic [15:0] DEF_OPEN_VAL [0:3] = '{16'h0000, 16'h0000, 16'h0000, 16'h0004};
  localparam logic [15:0] DEF_CLOSE_MASK [0:3] = '{16'h0000, 16'h0010, 16'h0014, 16'h0004};
  localparam logic [15:0] DEF_CLOSE_VAL [0:3] = '{16'h0000, 16'h0010, 16'h0014, 16'h0004};

  ////////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [15:0] LED_RST = 16'h0000;
  localparam logic [3:0] SIG_RST = 4'h0;

endpackage : prot_ctrl_pkg

// >>> design/input_sync.sv
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: inputs are slow contacts, any glitch filtering is done downstream
// Notes: the first stage is read only by the second stage
`timescale 1ns/100ps
module input_sync #(
  parameter int N = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [N-1:0] raw,
  output logic [N-1:0] sync
);

  logic [N-1:0] meta_ff;

  // two-stage capture against metastability
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_ff <= '0;
      sync <= '0;
    end else begin
      meta_ff <= raw;
      sync <= meta_ff;
    end
  end

endmodule : input_sync

// >>> design/stage_timer.sv
// Purpose: one protection stage: start comparison, operate timer, trip
// Assumes: tick is a one-cycle pulse every millisecond
// Notes: inverse mode integrates the excess current, so larger faults trip sooner
`timescale 1ns/100ps
module stage_timer #(
  parameter int CUR_W = prot_ctrl_pkg::CUR_W,
  parameter int TIME_W = prot_ctrl_pkg::TIME_W,
  parameter int ACC_W = prot_ctrl_pkg::ACC_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic [CUR_W-1:0] level,
  input wire logic [CUR_W-1:0] start_set,
  input wire logic [TIME_W-1:0] time_set,
  input wire prot_ctrl_pkg::char_t mode,
  input wire logic block,
  output logic start_o,
  output logic trip_o
);

  logic started;
  logic [ACC_W-1:0] acc_ff;
  logic [ACC_W-1:0] thr;

  assign started = !block && (level > start_set);
  assign thr = (mode == prot_ctrl_pkg::CHAR_INVERSE) ?
               ACC_W'(time_set) * ACC_W'(prot_ctrl_pkg::INV_SCALE) : ACC_W'(time_set);

  // definite or inverse accumulation; saturates instead of wrapping
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_ff <= '0;
    end else if (!started) begin
      acc_ff <= '0;
    end else if (tick && acc_ff < thr) begin
      if (mode == prot_ctrl_pkg::CHAR_INVERSE) begin
        acc_ff <= acc_ff + ACC_W'(level - start_set);
      end else begin
        acc_ff <= acc_ff + ACC_W'(1);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      start_o <= 1'b0;
      trip_o <= 1'b0;
    end else begin
      start_o <= started;
      trip_o <= started && (mode == prot_ctrl_pkg::CHAR_INSTANT || acc_ff >= thr);
    end
  end

  chk_start_on_exceed: assert property (@(posedge clk) disable iff (rst)
    started |=> start_o) else $error("stage did not start on exceed");
  chk_trip_needs_start: assert property (@(posedge clk) disable iff (rst)
    trip_o |-> start_o) else $error("trip without start");
  chk_instant_trip: assert property (@(posedge clk) disable iff (rst)
    started && mode == prot_ctrl_pkg::CHAR_INSTANT |=> trip_o)
    else $error("instant stage did not trip");
  chk_definite_wait: assert property (@(posedge clk) disable iff (rst)
    mode == prot_ctrl_pkg::CHAR_DEFINITE && acc_ff < thr |=> !trip_o)
    else $error("definite stage tripped early");
  cov_stage_trip: cover property (@(posedge clk) disable iff (rst) $rose(trip_o));

endmodule : stage_timer

// >>> design/feeder_prot_ctrl.sv
// Purpose: protection decision, contact routing and switching control of a feeder terminal
// Assumes: currents and remote commands come from logic on clk; contacts are pins
// Notes: open outputs have priority over close; protection trips skip interlocking
`timescale 1ns/100ps
module feeder_prot_ctrl #(
  parameter int TICK_CYCLES = prot_ctrl_pkg::TICK_CYCLES,
  parameter int PULSE_TICKS = prot_ctrl_pkg::PULSE_TICKS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [prot_ctrl_pkg::CUR_W-1:0] phase_i_a,
  input wire logic [prot_ctrl_pkg::CUR_W-1:0] phase_i_b,
  input wire logic [prot_ctrl_pkg::CUR_W-1:0] phase_i_c,
  input wire logic [prot_ctrl_pkg::CUR_W-1:0] resid_i,
  input wire logic [2:0] phase_enable,
  input wire logic [4*prot_ctrl_pkg::CUR_W-1:0] stage_start_set,
  input wire logic [4*prot_ctrl_pkg::TIME_W-1:0] stage_time_set,
  input wire prot_ctrl_pkg::char_t oc_low_char,
  input wire logic oc_high_instant,
  input wire prot_ctrl_pkg::char_t ef_low_char,
  input wire logic ext_ctrl_pin,
  input wire logic [3:0] ext_block_sel,
  input wire logic ext_trip_sel,
  input wire logic [2:0] status_open_pin,
  input wire logic [2:0] status_closed_pin,
  input wire logic [5:0] general_pin,
  input wire logic [9:0] gen_active_high,
  input wire logic [11:0] led_sel,
  input wire logic local_open_btn,
  input wire logic local_close_btn,
  input wire logic remote_key,
  input wire logic remote_open_cmd,
  input wire logic remote_close_cmd,
  input wire logic [1:0] ilk_scheme,
  input wire logic ilk_user_en,
  input wire logic [15:0] ilk_open_mask,
  input wire logic [15:0] ilk_open_val,
  input wire logic [15:0] ilk_close_mask,
  input wire logic [15:0] ilk_close_val,
  input wire logic [9:0] gen_open_sel,
  input wire logic [9:0] gen_close_sel,
  input wire logic [31:0] sig_prot_map,
  input wire logic [39:0] sig_gen_map,
  input wire logic dctl_en,
  input wire logic dctl_key_remote,
  input wire logic [15:0] dctl_open_mask,
  input wire logic [15:0] dctl_open_val,
  input wire logic [15:0] dctl_close_mask,
  input wire logic [15:0] dctl_close_val,
  input wire logic [15:0] dctl_sig_mask,
  input wire logic [15:0] dctl_sig_val,
  input wire logic [3:0] dctl_sig_en,
  input wire logic double_pole,
  input wire logic self_fault,
  output logic [3:0] stage_start,
  output logic [3:0] stage_trip,
  output logic brk_open_pos,
  output logic brk_open_neg,
  output logic brk_close_pos,
  output logic brk_close_neg,
  output logic [3:0] signal_out,
  output logic internal_failure_output,
  output logic [15:0] led_matrix,
  output logic [5:0] input_led,
  output logic cmd_cancel
);

  localparam int CW = prot_ctrl_pkg::CUR_W;
  localparam int TW = prot_ctrl_pkg::TIME_W;

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and millisecond tick

  logic [prot_ctrl_pkg::SYNC_W-1:0] pin_sync;
  logic ext_act;
  logic [2:0] st_open;
  logic [2:0] st_closed;
  logic [5:0] ext_in;
  logic btn_open;
  logic btn_close;
  logic key_remote;
  logic [prot_ctrl_pkg::TICK_W-1:0] tick_cnt_ff;
  logic tick_ff;

  input_sync #(.N(prot_ctrl_pkg::SYNC_W)) u_sync (
    .clk(clk),
    .rst(rst),
    .raw({ext_ctrl_pin, status_open_pin, status_closed_pin, general_pin,
          local_open_btn, local_close_btn, remote_key}),
    .sync(pin_sync)
  );

  assign {ext_act, st_open, st_closed, ext_in, btn_open, btn_close, key_remote} = pin_sync;

  // divider: one-cycle enable every millisecond
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else if (tick_cnt_ff == prot_ctrl_pkg::TICK_W'(TICK_CYCLES - 1)) begin
      tick_cnt_ff <= '0;
      tick_ff <= 1'b1;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + prot_ctrl_pkg::TICK_W'(1);
      tick_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // protection stages

  logic [CW-1:0] pa;
  logic [CW-1:0] pb;
  logic [CW-1:0] pc;
  logic [CW-1:0] phase_max;
  logic [CW-1:0] stg_level [4];
  prot_ctrl_pkg::char_t stg_mode [4];
  logic ext_force_trip;
  logic trip_any;

  assign pa = phase_enable[0] ? phase_i_a : '0;
  assign pb = phase_enable[1] ? phase_i_b : '0;
  assign pc = phase_enable[2] ? phase_i_c : '0;
  assign phase_max = (pa > pb) ? ((pa > pc) ? pa : pc) : ((pb > pc) ? pb : pc);

  // residual current feeds both earth stages
  assign stg_level[prot_ctrl_pkg::STG_OC_LOW] = phase_max;
  assign stg_level[prot_ctrl_pkg::STG_OC_HIGH] = phase_max;
  assign stg_level[prot_ctrl_pkg::STG_EF_LOW] = resid_i;
  assign stg_level[prot_ctrl_pkg::STG_EF_HIGH] = resid_i;
  assign stg_mode[prot_ctrl_pkg::STG_OC_LOW] = oc_low_char;
  assign stg_mode[prot_ctrl_pkg::STG_OC_HIGH] = oc_high_instant ?
         prot_ctrl_pkg::CHAR_INSTANT : prot_ctrl_pkg::CHAR_DEFINITE;
  assign stg_mode[prot_ctrl_pkg::STG_EF_LOW] = (ef_low_char == prot_ctrl_pkg::CHAR_INVERSE) ?
         prot_ctrl_pkg::CHAR_INVERSE : prot_ctrl_pkg::CHAR_DEFINITE;
  assign stg_mode[prot_ctrl_pkg::STG_EF_HIGH] = prot_ctrl_pkg::CHAR_DEFINITE;

  for (genvar s = 0; s < prot_ctrl_pkg::NUM_STAGES; s++) begin : g_stage
    stage_timer u_stage (
      .clk(clk),
      .rst(rst),
      .tick(tick_ff),
      .level(stg_level[s]),
      .start_set(stage_start_set[s*CW +: CW]),
      .time_set(stage_time_set[s*TW +: TW]),
      .mode(stg_mode[s]),
      .block(ext_act && ext_block_sel[s]),
      .start_o(stage_start[s]),
      .trip_o(stage_trip[s])
    );
  end

  // forced trip; trips never pass interlocking
  assign ext_force_trip = ext_act && ext_trip_sel;
  assign trip_any = (|stage_trip) || ext_force_trip;

  ////////////////////////////////////////////////////////////////////////////////
  // general inputs, indicators and interlock vector

  logic [9:0] gen_raw;
  logic [9:0] gen_act;
  logic [9:0] gen_prev_ff;
  logic [15:0] ilk_vec;

  // channels: six pins, then oc start/trip and ef start/trip
  assign gen_raw = {stage_trip[2] | stage_trip[3], stage_start[2] | stage_start[3],
                    stage_trip[0] | stage_trip[1], stage_start[0] | stage_start[1], ext_in};
  assign gen_act = gen_raw ^ ~gen_active_high;
  assign ilk_vec = {gen_act, st_closed, st_open};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      input_led <= '0;
      gen_prev_ff <= '0;
    end else begin
      input_led <= gen_act[5:0];
      gen_prev_ff <= gen_act;
    end
  end

  // each lit position shows its object closed
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      led_matrix <= prot_ctrl_pkg::LED_RST;
    end else begin
      for (int i = 0; i < 16; i++) begin
        led_matrix[i] <= (led_sel[3:0] == 4'(i) && st_closed[0]) ||
                         (led_sel[7:4] == 4'(i) && st_closed[1]) ||
                         (led_sel[11:8] == 4'(i) && st_closed[2]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // command sources

  logic btn_prev_open_ff;
  logic btn_prev_close_ff;
  logic [2:0] dctl_prev_ff;
  logic dctl_key_ok;
  logic dctl_open_c;
  logic dctl_close_c;
  logic dctl_sig_c;
  logic req_open;
  logic req_close;

  // direct program conditions, gated by the key switch
  assign dctl_key_ok = dctl_en && (key_remote == dctl_key_remote);
  assign dctl_open_c = dctl_key_ok && ((ilk_vec & dctl_open_mask) == (dctl_open_val & dctl_open_mask));
  assign dctl_close_c = dctl_key_ok &&
                        ((ilk_vec & dctl_close_mask) == (dctl_close_val & dctl_close_mask));
  assign dctl_sig_c = dctl_key_ok && ((ilk_vec & dctl_sig_mask) == (dctl_sig_val & dctl_sig_mask));

  // edge memories; a held button or condition gives one command only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      btn_prev_open_ff <= 1'b0;
      btn_prev_close_ff <= 1'b0;
      dctl_prev_ff <= '0;
    end else begin
      btn_prev_open_ff <= btn_open;
      btn_prev_close_ff <= btn_close;
      dctl_prev_ff <= {dctl_sig_c, dctl_close_c, dctl_open_c};
    end
  end

  // local buttons in local, serial commands in remote; input edges
  assign req_open = (!key_remote && btn_open && !btn_prev_open_ff) ||
                    (key_remote && remote_open_cmd) ||
                    |(gen_act & ~gen_prev_ff & gen_open_sel) ||
                    (dctl_open_c && !dctl_prev_ff[0]);
  assign req_close = (!key_remote && btn_close && !btn_prev_close_ff) ||
                     (key_remote && remote_close_cmd) ||
                     |(gen_act & ~gen_prev_ff & gen_close_sel) ||
                     (dctl_close_c && !dctl_prev_ff[1]);

  ////////////////////////////////////////////////////////////////////////////////
  // interlocking and output pulse sequencer

  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_CHECK = 4'b0010,
    S_OPEN = 4'b0100,
    S_CLOSE = 4'b1000
  } ctrl_state_t;

  ctrl_state_t state_ff;
  logic dir_open_ff;
  logic [prot_ctrl_pkg::PULSE_W-1:0] pulse_cnt_ff;
  logic permit_open;
  logic permit_close;
  logic permit;

  // default scheme unless a user program is loaded
  assign permit_open = ilk_user_en ?
         ((ilk_vec & ilk_open_mask) == (ilk_open_val & ilk_open_mask)) :
         ((ilk_vec & prot_ctrl_pkg::DEF_OPEN_MASK[ilk_scheme]) ==
          prot_ctrl_pkg::DEF_OPEN_VAL[ilk_scheme]);
  assign permit_close = ilk_user_en ?
         ((ilk_vec & ilk_close_mask) == (ilk_close_val & ilk_close_mask)) :
         ((ilk_vec & prot_ctrl_pkg::DEF_CLOSE_MASK[ilk_scheme]) ==
          prot_ctrl_pkg::DEF_CLOSE_VAL[ilk_scheme]);
  assign permit = dir_open_ff ? permit_open : permit_close;

  // check, then execute or cancel; busy states drop new requests
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= S_IDLE;
      dir_open_ff <= 1'b0;
      pulse_cnt_ff <= '0;
      cmd_cancel <= 1'b0;
    end else begin
      cmd_cancel <= 1'b0;
      unique case (state_ff)
        S_IDLE: begin
          if (req_open || req_close) begin
            dir_open_ff <= req_open; // open wins a tie, it is the safe direction
            state_ff <= S_CHECK;
          end
        end
        S_CHECK: begin
          pulse_cnt_ff <= '0;
          if (!permit) begin
            cmd_cancel <= 1'b1;
            state_ff <= S_IDLE;
          end else begin
            state_ff <= dir_open_ff ? S_OPEN : S_CLOSE;
          end
        end
        S_OPEN, S_CLOSE: begin
          if (tick_ff) begin
            if (pulse_cnt_ff == prot_ctrl_pkg::PULSE_W'(PULSE_TICKS - 1)) begin
              state_ff <= S_IDLE;
            end else begin
              pulse_cnt_ff <= pulse_cnt_ff + prot_ctrl_pkg::PULSE_W'(1);
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // breaker and signalling contacts

  logic open_drive;
  logic close_drive;
  logic [3:0] sig_next;

  // any trip opens; close is suppressed while opening
  assign open_drive = trip_any || (state_ff == S_OPEN);
  assign close_drive = (state_ff == S_CLOSE) && !trip_any;

  // start and trip routing; four outputs; direct program
  for (genvar k = 0; k < prot_ctrl_pkg::NUM_SIG; k++) begin : g_sig
    assign sig_next[k] = |({stage_trip, stage_start} & sig_prot_map[k*8 +: 8]) ||
                         |(gen_act & sig_gen_map[k*10 +: 10]) ||
                         (dctl_sig_en[k] && dctl_sig_c);
  end

  // second pole only switched in double-pole wiring
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      brk_open_pos <= 1'b0;
      brk_open_neg <= 1'b0;
      brk_close_pos <= 1'b0;
      brk_close_neg <= 1'b0;
    end else begin
      brk_open_pos <= open_drive;
      brk_open_neg <= open_drive && double_pole;
      brk_close_pos <= close_drive;
      brk_close_neg <= close_drive && double_pole;
    end
  end

  // signals stay as long as their sources; failure output
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      signal_out <= prot_ctrl_pkg::SIG_RST;
      internal_failure_output <= 1'b0;
    end else begin
      signal_out <= sig_next;
      internal_failure_output <= self_fault;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  chk_trip_opens_breaker: assert property (@(posedge clk) disable iff (rst)
    trip_any |=> brk_open_pos && !brk_close_pos) else $error("trip did not open breaker");
  chk_single_pole_idle: assert property (@(posedge clk) disable iff (rst)
    !double_pole |=> !brk_open_neg && !brk_close_neg) else $error("second pole driven");
  chk_ext_force_trip: assert property (@(posedge clk) disable iff (rst)
    ext_force_trip |=> brk_open_pos) else $error("forced trip missing");
  chk_cancel_on_deny: assert property (@(posedge clk) disable iff (rst)
    state_ff == S_CHECK && !permit |=> cmd_cancel && state_ff == S_IDLE)
    else $error("denied command not cancelled");
  chk_execute_on_permit: assert property (@(posedge clk) disable iff (rst)
    state_ff == S_CHECK && permit |=> state_ff inside {S_OPEN, S_CLOSE})
    else $error("permitted command not executed");
  chk_busy_ignores: assert property (@(posedge clk) disable iff (rst)
    state_ff inside {S_OPEN, S_CLOSE} && !tick_ff |=> $stable(state_ff) && $stable(dir_open_ff))
    else $error("request disturbed running pulse");
  chk_pulse_ends: assert property (@(posedge clk) disable iff (rst)
    state_ff == S_CLOSE && tick_ff && pulse_cnt_ff == prot_ctrl_pkg::PULSE_W'(PULSE_TICKS - 1)
    |=> state_ff == S_IDLE ##1 !brk_close_pos) else $error("pulse did not end");
  chk_input_led: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> input_led == $past(gen_act[5:0])) else $error("indicator mismatch");
  chk_signal_level: assert property (@(posedge clk) disable iff (rst)
    |(gen_act & sig_gen_map[9:0]) |=> signal_out[0]) else $error("signal dropped");

  cov_open_pulse: cover property (@(posedge clk) disable iff (rst) $rose(brk_open_pos));
  cov_close_pulse: cover property (@(posedge clk) disable iff (rst) $rose(brk_close_pos));
  cov_cancel: cover property (@(posedge clk) disable iff (rst) cmd_cancel);

endmodule : feeder_prot_ctrl

// >>> testbench/breaker_model.sv
// Purpose: switchgear seen by the terminal: a breaker driven by its coils, two fixed objects
// Assumes: coil outputs are levels, sampled on clk
// Notes: both contacts of each object are driven, so no status pin ever floats
`timescale 1ns/100ps
module breaker_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic open_coil,
  input wire logic close_coil,
  output logic [2:0] open_pin,
  output logic [2:0] closed_pin
);
  logic closed_ff;
  ////////////////////////////////////////////////////////////////////////////////
  // breaker moves on a coil, open coil first since a trip must win
  always_ff @(posedge clk or posedge rst) begin
    if (rst) closed_ff <= 1'b1;
    else if (open_coil) closed_ff <= 1'b0;
    else if (close_coil) closed_ff <= 1'b1;
  end
  assign open_pin = {1'b1, 1'b0, ~closed_ff};
  assign closed_pin = {1'b0, 1'b1, closed_ff};
endmodule : breaker_model

// >>> testbench/tb_feeder_prot_ctrl.sv
// Purpose: self-checking bench of the feeder protection and control logic
// Assumes: short tick and pulse counts so timers finish quickly
// Notes: breaker_model closes the loop from the coils back to the status pins
`timescale 1ns/100ps
module tb_feeder_prot_ctrl;
  localparam int TC = 10;
  localparam int PT = 3;
  logic clk, rst = 1'b1, oc_high_instant = 0, ext_ctrl_pin = 0, ext_trip_sel = 0;
  logic local_open_btn = 0, local_close_btn = 0, remote_key = 1, remote_open_cmd = 0;
  logic remote_close_cmd = 0, ilk_user_en = 1, dctl_en = 0, dctl_key_remote = 0;
  logic double_pole = 1, self_fault = 0, brk_open_pos, brk_open_neg, brk_close_pos;
  logic brk_close_neg, internal_failure_output, cmd_cancel;
  logic [11:0] phase_i_a = 0, phase_i_b = 0, phase_i_c = 0, resid_i = 0, led_sel = 0;
  logic [2:0] phase_enable = 3'h7, status_open_pin, status_closed_pin;
  // ef high 0x300, ef low 0x200, oc high 0x400, oc low 0x100
  logic [47:0] stage_start_set = 48'h3002_0040_0100;
  logic [63:0] stage_time_set = 64'h0002_0002_0002_0002;
  prot_ctrl_pkg::char_t oc_low_char = prot_ctrl_pkg::CHAR_DEFINITE;
  prot_ctrl_pkg::char_t ef_low_char = prot_ctrl_pkg::CHAR_DEFINITE;
  logic [3:0] ext_block_sel = 0, dctl_sig_en = 0, stage_start, stage_trip, signal_out;
  logic [5:0] general_pin = 0, input_led;
  logic [9:0] gen_active_high = 0, gen_open_sel = 0, gen_close_sel = 0;
  logic [1:0] ilk_scheme = 0;
  logic [15:0] ilk_open_mask = 16'h0001, ilk_open_val = 0, ilk_close_mask = 0;
  logic [15:0] ilk_close_val = 0, led_matrix, dctl_open_mask = 0, dctl_open_val = 0;
  logic [15:0] dctl_close_mask = 0, dctl_close_val = 0, dctl_sig_mask = 0, dctl_sig_val = 0;
  logic [31:0] sig_prot_map = 32'h0000_0001;
  logic [39:0] sig_gen_map = 0;
  int miscompares, compares, seed = 51, n, w, c;
  feeder_prot_ctrl #(.TICK_CYCLES(TC), .PULSE_TICKS(PT)) uut (.*);
  breaker_model sw (.clk(clk), .rst(rst), .open_coil(brk_open_pos),
    .close_coil(brk_close_pos), .open_pin(status_open_pin), .closed_pin(status_closed_pin));
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input logic [15:0] e, input logic [15:0] a);
    compares++;
    if (a !== e) begin
      miscompares++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, a);
    end
  endtask : chk
  // one remote request, then a window long enough for a whole pulse
  task cmd(input logic op);
    @(posedge clk);
    remote_open_cmd <= op;
    remote_close_cmd <= !op;
    @(posedge clk);
    remote_open_cmd <= 1'b0;
    remote_close_cmd <= 1'b0;
    w = 0;
    c = 0;
    repeat (PT * TC + 10) begin
      @(negedge clk);
      w += int'((op ? brk_open_pos : brk_close_pos) === 1'b1);
      c += int'(cmd_cancel === 1'b1);
    end
  endtask : cmd
  task wrap_up;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // a full run needs far less than this span
  initial begin
    #400000;
    miscompares++;
    wrap_up();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk(16'({stage_trip, brk_open_pos, brk_close_pos}), 16'h0);
    @(posedge clk);
    phase_i_c <= 12'h150;
    repeat (2) @(negedge clk);
    chk(16'(stage_start[0]), 16'h1);
    for (n = 0; n < 4 * TC && stage_trip[0] !== 1'b1; n++) @(negedge clk);
    chk(16'(n >= TC - 2 && n <= 3 * TC), 16'h1);
    @(negedge clk);
    chk(16'({brk_open_pos, brk_open_neg, signal_out[0]}), 16'h7);
    // random currents and phase sets against a max-of-phases model
    for (int i = 0; i < 12; i++) begin
      @(posedge clk);
      phase_i_a <= 12'($random(seed));
      phase_i_b <= 12'($random(seed));
      phase_enable <= 3'($random(seed));
      resid_i <= 12'($random(seed));
      general_pin <= 6'($random(seed));
      gen_active_high <= {10{i[0]}};
      repeat (2) @(negedge clk);
      chk(16'((phase_enable[0] && phase_i_a > 12'h400) || (phase_enable[1] && phase_i_b > 12'h400)
        || (phase_enable[2] && phase_i_c > 12'h400)), 16'(stage_start[1]));
      chk(16'(resid_i > 12'h300), 16'(stage_start[3]));
      repeat (3) @(negedge clk);
      chk(16'(general_pin ^ {6{!i[0]}}), 16'(input_led));
    end
    @(posedge clk);
    {ext_ctrl_pin, ext_block_sel, ext_trip_sel, self_fault} <= 7'h7F;
    phase_i_c <= 12'h150;
    repeat (6) @(negedge clk);
    chk(16'({stage_start[0], brk_open_pos, internal_failure_output}), 16'h3);
    @(posedge clk);
    {ext_ctrl_pin, ext_trip_sel, phase_i_a, phase_i_b, phase_i_c, resid_i} <= 0;
    repeat (8) @(posedge clk);
    cmd(1'b0);
    chk(16'({c[3:0], w > (PT - 1) * TC && w <= PT * TC + 1}), 16'h1);
    cmd(1'b1);
    chk(16'({c[3:0], w > (PT - 1) * TC && w <= PT * TC + 1}), 16'h1);
    cmd(1'b1);
    chk(16'({c[3:0], w[0]}), 16'h2);
    chk(16'h0001, led_matrix);
    wrap_up();
  end
endmodule : tb_feeder_prot_ctrl
